// *** core_timing_pkg.sv ***
// Purpose: Shared constants for the machine-cycle sequencer and timer rate generator.
// Assumes: One oscillator clock; every slower rate is an enable pulse.
// Notes: Opcode encodings live in the decode functions of the sequencer.
package core_timing_pkg;

  // Machine cycle framing
  localparam int unsigned CLKS_PER_MCYCLE = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_MCYCLE - 1);
  localparam logic [1:0] ADDR_LATCH_PHASE = 2'h0;
  localparam logic [1:0] PHASE_RESET = PHASE_LAST;

  // Timer increment rates in oscillator clocks
  localparam int unsigned LEGACY_TIMER_CLKS = 12;
  localparam int unsigned FAST_TIMER_CLKS = 4;
  localparam logic [3:0] LEGACY_TIMER_LAST = 4'(LEGACY_TIMER_CLKS - 1);
  localparam logic [3:0] FAST_TIMER_LAST = 4'(FAST_TIMER_CLKS - 1);

  // Instruction timing in machine cycles
  localparam logic [3:0] MOVE_MIN_CYCLES = 4'h2;
  localparam logic [3:0] MAX_INSTR_CYCLES = 4'h5;
  localparam int unsigned STRETCH_W = 3;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {br_none, br_rel, br_abs11, br_long16} branch_kind_type;

endpackage

// *** timer_rate_gen.sv ***
// Purpose: Counter/timer increment enable at the legacy or the fast rate.
// Assumes: fast_rate comes from logic on sys_clk.
// Notes: A rate change restarts the count so no short interval is produced.
`timescale 1ns/1ps
`default_nettype none
module timer_rate_gen
  import core_timing_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Rate select
  input wire logic fast_rate,
  // Increment enable
  output logic tick_q
);

  logic [3:0] div_q;
  logic [3:0] div_d;
  logic fast_q;
  wire logic [3:0] last_count = fast_rate ? FAST_TIMER_LAST : LEGACY_TIMER_LAST;
  wire logic rate_changed = fast_q != fast_rate;
  wire logic wrap = (div_q >= last_count) && !rate_changed;

  assign div_d = (wrap || rate_changed) ? 4'h0 : div_q + 4'h1;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= 4'h0;
      fast_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      fast_q <= fast_rate;
      tick_q <= wrap;
    end
  end

endmodule // timer_rate_gen
`default_nettype wire

// *** core_instruction_timing.sv ***
// What this block does
// - Each machine cycle lasts exactly four oscillator clocks.
// - One address-latch strobe pulse is produced in every machine cycle.
// - With the legacy rate selected (fast_timer low), timers increment once every twelve oscillator clocks.
// - With the fast rate selected, timers increment every four clocks.
// - An external data move takes at least two machine cycles.
// - A direct-to-direct move takes three machine cycles.
// - Mostly one machine cycle per instruction byte fetched.
// - Unstretched instructions take between one and five machine cycles.
// - Operations and flag effects match the legacy set; only timing differs.
// - A relative branch adds one signed offset byte to the program counter.
// - Immediates 8 and 16 bits, long targets 16 bits, absolute targets 11 bits.
// - External data move length is selectable so slow devices get extra cycles.
// - Fully static logic; state is kept with the clock slowed or stopped.
//
// Purpose: Machine-cycle phasing, byte fetch, cycle counting and branch targets.
// Assumes: code_byte answers code_addr_q within one machine cycle; cond_true,
//   pc_load, fast_timer and move_stretch come from logic on sys_clk.
// Notes: Flag and data semantics stay in the execution unit outside.
`timescale 1ns/1ps
`default_nettype none
module core_instruction_timing
  import core_timing_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Program memory
  input wire logic [7:0] code_byte,
  output logic [15:0] code_addr_q,
  // Execution unit hand-off
  input wire logic cond_true,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_addr,
  // Configuration
  input wire logic fast_timer,
  input wire logic [STRETCH_W-1:0] move_stretch,
  // Timing outputs
  output logic [1:0] phase_q,
  output logic addr_latch_q,
  output logic mcycle_end_q,
  output logic instr_done_q,
  output logic ext_access_q,
  output logic timer_tick_q,
  // Decoded instruction
  output logic [7:0] opcode_q,
  output logic [7:0] imm8_q,
  output logic [15:0] imm16_q,
  output logic [15:0] branch_target_q
);

  typedef enum {st_opcode, st_operand, st_execute} seq_state_type;

  seq_state_type state_q;
  seq_state_type state_d;
  logic [3:0] cyc_q;
  logic [1:0] len_q;
  logic [3:0] total_q;
  logic move_q;
  logic [7:0] op1_q;
  logic [7:0] op2_q;

  // Instruction length in bytes
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    logic three;
    logic two;
    three = (op inside {8'h02, 8'h10, 8'h12, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63,
                        8'h75, 8'h85, 8'h90, 8'hD5}) || (op[7:4] == 4'hB && op[3:2] != 2'h0);
    two = (op[3:0] == 4'h1) || (op[7:4] == 4'h7 && op[3])
       || (op[7:3] inside {5'h11, 5'h15, 5'h1B})
       || (op inside {8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h40, 8'h42, 8'h44,
                      8'h45, 8'h50, 8'h52, 8'h54, 8'h55, 8'h60, 8'h62, 8'h64, 8'h65,
                      8'h70, 8'h72, 8'h74, 8'h76, 8'h77, 8'h80, 8'h82, 8'h86, 8'h87,
                      8'h92, 8'h94, 8'h95, 8'hA0, 8'hA2, 8'hA6, 8'hA7, 8'hB0, 8'hB2,
                      8'hC0, 8'hC2, 8'hC5, 8'hD0, 8'hD2, 8'hE5, 8'hF5});
    return three ? 2'h3 : (two ? 2'h2 : 2'h1);
  endfunction

  // External data move opcodes, both pointer forms, read and write
  function automatic logic is_ext_move(input logic [7:0] op);
    return op inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
  endfunction

  // Machine cycles per instruction, stretch excluded
  function automatic logic [3:0] instr_cycles(input logic [7:0] op);
    logic [3:0] n;
    n = {2'h0, instr_len(op)};
    if (op inside {8'h84, 8'hA4})
      n = MAX_INSTR_CYCLES;
    else if (is_ext_move(op))
      n = MOVE_MIN_CYCLES;
    else if (op inside {8'h02, 8'h12, 8'h22, 8'h32, 8'h10, 8'h20, 8'h30, 8'hD5}
             || (op[7:4] == 4'hB && op[3:2] != 2'h0))
      n = 4'h4;
    else if (op inside {8'h40, 8'h50, 8'h60, 8'h70, 8'h73, 8'h80, 8'h83, 8'h93, 8'hA3}
             || op[3:0] == 4'h1 || op[7:3] == 5'h1B)
      n = 4'h3;
    return n; // follows from three bytes fetched for direct-to-direct
  endfunction

  // Where the branch target comes from
  function automatic branch_kind_type branch_kind(input logic [7:0] op);
    branch_kind_type k;
    k = br_none;
    if (op[3:0] == 4'h1)
      k = br_abs11;
    else if (op inside {8'h02, 8'h12})
      k = br_long16;
    else if (op inside {8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'hD5}
             || op[7:3] == 5'h1B || (op[7:4] == 4'hB && op[3:2] != 2'h0))
      k = br_rel;
    return k;
  endfunction

  // Phase and cycle boundaries
  wire logic cycle_end = phase_q == PHASE_LAST;
  wire logic [1:0] phase_d = cycle_end ? PHASE_FIRST : phase_q + 2'h1;

  // Decode of the byte arriving in the opcode cycle
  wire logic [1:0] new_len = instr_len(code_byte);
  wire logic new_move = is_ext_move(code_byte);
  wire logic [3:0] new_total = instr_cycles(code_byte)
                             + (new_move ? {1'b0, move_stretch} : 4'h0);

  // Byte fetch and instruction end
  wire logic [3:0] cyc_next = cyc_q + 4'h1;
  wire logic [3:0] total_now = (state_q == st_opcode) ? new_total : total_q;
  wire logic [1:0] len_now = (state_q == st_opcode) ? new_len : len_q;
  wire logic fetching = {2'h0, len_now} > cyc_q;
  wire logic last_cycle = cyc_next >= total_now;

  // Branch target forming
  wire branch_kind_type kind = branch_kind(opcode_q);
  wire logic three_byte_rel = instr_len(opcode_q) == 2'h3;
  wire logic [7:0] rel_byte = three_byte_rel ? op2_q : op1_q;
  wire logic [15:0] rel_target = code_addr_q + {{8{rel_byte[7]}}, rel_byte};
  wire logic [15:0] abs_target = {code_addr_q[15:11], opcode_q[7:5], op1_q};
  wire logic [15:0] long_target = {op1_q, op2_q};
  wire logic uncond = (opcode_q inside {8'h02, 8'h12, 8'h80}) || opcode_q[3:0] == 4'h1;
  wire logic [15:0] target_d = (kind == br_rel) ? rel_target
                             : (kind == br_abs11) ? abs_target
                             : long_target;
  wire logic take_branch = (kind != br_none) && (uncond || cond_true);

  // Next program address at the end of a machine cycle
  wire logic [15:0] pc_step = fetching ? code_addr_q + 16'h0001 : code_addr_q;
  wire logic [15:0] pc_d = (!last_cycle || state_q == st_opcode) ? pc_step
                         : pc_load ? pc_load_addr
                         : take_branch ? branch_target_q
                         : pc_step;

  always_comb
  begin
    state_d = state_q;
    if (last_cycle)
      state_d = st_opcode;
    else if ({2'h0, len_now} > cyc_next)
      state_d = st_operand;
    else
      state_d = st_execute;
  end

  // Phase counter and strobes; no dynamic nodes, so a stopped clock loses nothing
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q <= PHASE_RESET;
      addr_latch_q <= 1'b0;
      mcycle_end_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      addr_latch_q <= phase_d == ADDR_LATCH_PHASE;
      mcycle_end_q <= cycle_end;
    end
  end

  // Sequencer advances once per machine cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= st_opcode;
      cyc_q <= 4'h0;
      len_q <= 2'h1;
      total_q <= 4'h1;
      move_q <= 1'b0;
      code_addr_q <= PC_RESET;
      instr_done_q <= 1'b0;
      ext_access_q <= 1'b0;
    end
    else
    begin
      instr_done_q <= cycle_end && last_cycle;
      if (cycle_end)
      begin
        state_q <= state_d;
        cyc_q <= last_cycle ? 4'h0 : cyc_next;
        code_addr_q <= pc_d;
        if (state_q == st_opcode)
        begin
          len_q <= new_len;
          total_q <= new_total;
          move_q <= new_move;
        end
        // Bus access cycles follow the opcode cycle of the move
        ext_access_q <= !last_cycle && (state_q == st_opcode ? new_move : move_q);
      end
    end
  end

  // Opcode and operand capture; semantics are left to the execution unit
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      opcode_q <= BYTE_RESET;
      op1_q <= BYTE_RESET;
      op2_q <= BYTE_RESET;
      imm8_q <= BYTE_RESET;
      imm16_q <= PC_RESET;
      branch_target_q <= PC_RESET;
    end
    else
    begin
      branch_target_q <= target_d;
      if (cycle_end && fetching)
      begin
        unique case (cyc_q)
          4'h0: opcode_q <= code_byte;
          4'h1:
          begin
            op1_q <= code_byte;
            imm8_q <= code_byte;
          end
          default:
          begin
            op2_q <= code_byte;
            imm8_q <= code_byte;
            imm16_q <= {op1_q, code_byte};
          end
        endcase
      end
    end
  end

  timer_rate_gen u_timer_rate
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .fast_rate(fast_timer),
    .tick_q(timer_tick_q)
  );

endmodule // core_instruction_timing
`default_nettype wire

// *** core_instruction_timing_checker.sv ***
// Purpose: Timing assertions on the ports of the instruction timing block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: The first timer tick after reset or a rate change is not measured.
`timescale 1ns/1ps
`default_nettype none
module core_instruction_timing_checker
  import core_timing_pkg::*;
(
  // Clock, reset and configuration
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic fast_timer,
  input wire logic [STRETCH_W-1:0] move_stretch,
  // Timing outputs
  input wire logic [15:0] code_addr_q,
  input wire logic [1:0] phase_q,
  input wire logic addr_latch_q,
  input wire logic mcycle_end_q,
  input wire logic instr_done_q,
  input wire logic ext_access_q,
  input wire logic timer_tick_q
);
  logic [3:0] gap_q;
  logic chg_q;
  logic ft_q;
  logic run_q;
  logic [3:0] gap_exp;
  assign gap_exp = fast_timer ? FAST_TIMER_LAST : LEGACY_TIMER_LAST;
  // Clocks since the last tick; reset or a rate change marks the next gap as a restart
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_q <= 4'h0;
      chg_q <= 1'b1;
      ft_q <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      ft_q <= fast_timer;
      run_q <= 1'b1;
      gap_q <= timer_tick_q ? 4'h0 : gap_q + 4'h1;
      // A change on a tick edge must still mark the next gap
      chg_q <= (fast_timer != ft_q) || (chg_q && !timer_tick_q);
    end
  end
  default clocking @(posedge sys_clk);
  endclocking
  // Held off until the first edge after release, when the outputs first move
  default disable iff (!run_q);
  AST_PHASE_WRAP: assert property ((phase_q == PHASE_LAST) |=> (phase_q == PHASE_FIRST))
    else $error("phase did not wrap after the last phase");
  AST_PHASE_STEP: assert property ((phase_q != PHASE_LAST) |=> (phase_q == $past(phase_q) + 2'h1))
    else $error("phase did not advance by one");
  AST_LATCH_AT_PHASE: assert property (addr_latch_q == (phase_q == ADDR_LATCH_PHASE))
    else $error("address latch strobe off its phase");
  AST_LATCH_ONCE: assert property ($rose(addr_latch_q) |=> !addr_latch_q [*3] ##1 addr_latch_q)
    else $error("address latch strobe not once per machine cycle");
  AST_MCYCLE_END: assert property (mcycle_end_q |-> addr_latch_q)
    else $error("machine cycle end away from phase zero");
  AST_DONE_ALIGN: assert property (instr_done_q |-> mcycle_end_q)
    else $error("instruction done not on a machine cycle end");
  AST_DONE_GAP: assert property (instr_done_q |=> !instr_done_q [*3])
    else $error("instruction shorter than one machine cycle");
  AST_EXT_MIN: assert property (($rose(ext_access_q) && move_stretch == 3'h0) |-> ext_access_q [*4] ##1 (!ext_access_q && instr_done_q))
    else $error("unstretched external move not two machine cycles");
  AST_EXT_STRETCH: assert property (($rose(ext_access_q) && move_stretch == 3'h1) |-> ext_access_q [*8] ##1 !ext_access_q)
    else $error("stretched external access has wrong length");
  AST_TIMER_GAP: assert property ((timer_tick_q && !chg_q && fast_timer == ft_q) |-> (gap_q == gap_exp))
    else $error("timer tick interval wrong for the selected rate");
  AST_ADDR_AT_FETCH: assert property ($changed(code_addr_q) |-> (phase_q == PHASE_FIRST))
    else $error("fetch address moved outside a cycle boundary");
endmodule // core_instruction_timing_checker

bind core_instruction_timing core_instruction_timing_checker chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .fast_timer(fast_timer),
  .move_stretch(move_stretch),
  .code_addr_q(code_addr_q),
  .phase_q(phase_q),
  .addr_latch_q(addr_latch_q),
  .mcycle_end_q(mcycle_end_q),
  .instr_done_q(instr_done_q),
  .ext_access_q(ext_access_q),
  .timer_tick_q(timer_tick_q)
);
`default_nettype wire

// *** code_rom_model.sv ***
// Purpose: Program memory model answering the core's fetch address.
// Assumes: The byte is settled well inside one machine cycle.
// Notes: The program ends in a short jump to itself so it never runs off.
`timescale 1ns/1ps
`default_nettype none
module code_rom_model (
  // Fetch address
  input wire logic [15:0] code_addr_q,
  // Returned byte
  output logic [7:0] code_byte
);
  always_comb
  begin
    case (code_addr_q)
      16'h0001: code_byte = 8'h85;
      16'h0002: code_byte = 8'h12;
      16'h0003: code_byte = 8'h34;
      16'h0004: code_byte = 8'hA4;
      16'h0005: code_byte = 8'hE0;
      16'h0006: code_byte = 8'h80;
      16'h0007: code_byte = 8'hFE;
      // Conditional branch loop, reached only by an indirect load
      16'h0010: code_byte = 8'h40;
      16'h0011: code_byte = 8'hFE;
      16'h0012: code_byte = 8'h80;
      16'h0013: code_byte = 8'hFE;
      default: code_byte = 8'h00;
    endcase
  end
endmodule // code_rom_model
`default_nettype wire

// *** core_instruction_timing_tb_top.sv ***
// Purpose: Self-checking bench for instruction timing and timer rates.
// Assumes: Program memory model holds a short program and a branch loop at 0x10.
// Notes: Branch condition and indirect load are driven only in test_branch.
`timescale 1ns/1ps
`default_nettype none
module core_instruction_timing_tb_top
  import core_timing_pkg::*;
;
  logic sys_clk, rst_b, cond_true, pc_load, fast_timer;
  logic [15:0] pc_load_addr, code_addr_q, imm16_q, branch_target_q;
  logic [STRETCH_W-1:0] move_stretch;
  logic [7:0] code_byte, opcode_q, imm8_q;
  logic [1:0] phase_q;
  logic addr_latch_q, mcycle_end_q, instr_done_q, ext_access_q, timer_tick_q;
  int errors, total_checks, cycles, n;
  core_instruction_timing uut (.sys_clk(sys_clk), .rst_b(rst_b), .code_byte(code_byte),
    .code_addr_q(code_addr_q), .cond_true(cond_true), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .fast_timer(fast_timer), .move_stretch(move_stretch),
    .phase_q(phase_q), .addr_latch_q(addr_latch_q), .mcycle_end_q(mcycle_end_q),
    .instr_done_q(instr_done_q), .ext_access_q(ext_access_q), .timer_tick_q(timer_tick_q),
    .opcode_q(opcode_q), .imm8_q(imm8_q), .imm16_q(imm16_q), .branch_target_q(branch_target_q));
  code_rom_model rom (.code_addr_q(code_addr_q), .code_byte(code_byte));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Clocks up to the next pulse of done (sel 0) or timer tick (sel 1)
  task automatic next_pulse(input bit sel, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    while (((sel ? timer_tick_q : instr_done_q) !== 1'b1) && cnt < 100);
    if ((sel ? timer_tick_q : instr_done_q) !== 1'b1)
      check("pulse wait", 16'h0000, 16'(cnt));
  endtask
  task automatic do_reset(input logic [2:0] stretch);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    move_stretch <= stretch;
    repeat (5) @(posedge sys_clk);
    check("reset phase", 16'h0003, 16'(phase_q));
    check("reset address", 16'h0000, code_addr_q);
    rst_b <= 1'b1;
  endtask
  task automatic test_program();
    do_reset(3'h0);
    next_pulse(1'b0, n);
    next_pulse(1'b0, n);
    check("mov direct clocks", 16'h000C, 16'(n));
    check("mov opcode", 16'h0085, 16'(opcode_q));
    check("long operand", 16'h1234, imm16_q);
    check("last operand", 16'h0034, 16'(imm8_q));
    next_pulse(1'b0, n);
    check("mul clocks", 16'h0014, 16'(n));
    next_pulse(1'b0, n);
    check("ext move clocks", 16'h0008, 16'(n));
    next_pulse(1'b0, n);
    check("sjmp clocks", 16'h000C, 16'(n));
    check("sjmp target", 16'h0006, branch_target_q);
    check("sjmp address", 16'h0006, code_addr_q);
    next_pulse(1'b0, n);
    check("sjmp loop address", 16'h0006, code_addr_q);
  endtask
  task automatic test_branch();
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_addr <= 16'h0010;
    next_pulse(1'b0, n);
    check("indirect load address", 16'h0010, code_addr_q);
    @(posedge sys_clk);
    pc_load <= 1'b0;
    cond_true <= 1'b1;
    next_pulse(1'b0, n);
    check("taken branch target", 16'h0010, branch_target_q);
    check("taken branch address", 16'h0010, code_addr_q);
    @(posedge sys_clk);
    cond_true <= 1'b0;
    next_pulse(1'b0, n);
    check("untaken branch address", 16'h0012, code_addr_q);
  endtask
  task automatic test_stretch();
    do_reset(3'h1);
    repeat (4) next_pulse(1'b0, n);
    check("stretch opcode", 16'h00E0, 16'(opcode_q));
    check("stretched move clocks", 16'h000C, 16'(n));
  endtask
  task automatic test_timer();
    next_pulse(1'b1, n);
    next_pulse(1'b1, n);
    check("legacy timer clocks", 16'h000C, 16'(n));
    @(posedge sys_clk);
    fast_timer <= 1'b1;
    repeat (2) next_pulse(1'b1, n);
    next_pulse(1'b1, n);
    check("fast timer clocks", 16'h0004, 16'(n));
    @(posedge sys_clk);
    fast_timer <= 1'b0;
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      complete_run();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    cond_true = 1'b0;
    pc_load = 1'b0;
    pc_load_addr = 16'h0000;
    fast_timer = 1'b0;
    move_stretch = 3'h0;
    test_program();
    test_branch();
    test_stretch();
    test_timer();
    complete_run();
  end
endmodule // core_instruction_timing_tb_top
`default_nettype wire
